/* rtl/superio_cfg_pkg.sv */
// Constants and carrier types for the configuration port block.
// Assumes one 50 MHz system clock and an ISA cycle source on pins.
package superio_cfg_pkg;

   // Port addresses
   localparam logic [15:0] PORT_BASE_HIGH  = 16'h03f0;
   localparam logic [15:0] PORT_BASE_LOW   = 16'h0370;
   localparam logic [15:0] DATA_PORT_OFS   = 16'h0001;

   // Key bytes
   localparam logic [7:0]  KEY_FIRST       = 8'h51;
   localparam logic [7:0]  KEY_SECOND      = 8'h23;
   localparam logic [7:0]  KEY_EXIT        = 8'hbb;

   // Register indexes
   localparam logic [7:0]  IDX_SOFT_RESET  = 8'h02;
   localparam logic [7:0]  IDX_LDN_SELECT  = 8'h07;
   localparam logic [7:0]  IDX_VERSION     = 8'h1f;
   localparam logic [7:0]  IDX_IDENT_LOW   = 8'h20;
   localparam logic [7:0]  IDX_IDENT_HIGH  = 8'h21;
   localparam logic [7:0]  IDX_DIRECT_PD   = 8'h22;
   localparam logic [7:0]  IDX_AUTO_PD     = 8'h23;
   localparam logic [7:0]  IDX_SERIAL_SWAP = 8'h2d;
   localparam logic [7:0]  IDX_LD_FIRST    = 8'h30;

   // Field positions
   localparam int          SOFT_RESET_BIT  = 0;
   localparam int          SWAP_BIT        = 5;
   localparam int          UNIT_FLOPPY     = 0;
   localparam int          UNIT_PARALLEL   = 3;
   localparam int          UNIT_SERIAL1    = 4;
   localparam int          UNIT_SERIAL2    = 5;
   localparam int          UNIT_SERIAL3    = 6;
   localparam int          UNIT_KEYBOARD   = 7;

   // Writable masks
   localparam logic [7:0]  DIRECT_PD_MASK  = 8'h79;
   localparam logic [7:0]  AUTO_PD_MASK    = 8'h78;
   localparam logic [7:0]  SWAP_MASK       = 8'h20;

   // Reset values
   localparam logic [7:0]  LDN_RESET       = 8'h00;
   localparam logic [7:0]  DIRECT_PD_RESET = 8'h00;
   localparam logic [7:0]  AUTO_PD_RESET   = 8'h00;
   localparam logic [7:0]  SWAP_RESET      = 8'h20;
   localparam logic [7:0]  ACTIVE_RESET    = 8'h80;

   // Timing counts
   localparam logic [1:0]  STRAP_SETTLE    = 2'h2;

   // Serial device numbers
   localparam logic [7:0]  SERIAL_LDN_A    = 8'h05;
   localparam logic [7:0]  SERIAL_LDN_B    = 8'h0b;

   typedef enum logic [1:0] {
      KEY_IDLE,
      KEY_ARMED,
      KEY_OPEN
   } key_state_type;

   // ISA cycle as seen at the pins
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0]  data;
      logic        wr;
      logic        rd;
   } io_cycle_type;

   // Forwarded access to the selected logical device set
   typedef struct packed {
      logic [7:0]  ldn;
      logic [7:0]  index;
      logic [7:0]  data;
      logic        wr;
      logic        rd;
   } ld_access_type;

endpackage

/* rtl/superio_config_port.sv */
// Configuration port, key detector and chip-level registers.
// Assumes ISA strobes and address from pins; logical device register
// sets sit outside and answer ld_read_data_i for the current index.
`timescale 1ns/1ps

module superio_config_port #(
   parameter logic [7:0] VERSION_VALUE = 8'h01, // Arbitrary value
   parameter logic [7:0] IDENT_LOW     = 8'ha5, // Arbitrary value
   parameter logic [7:0] IDENT_HIGH    = 8'h5a  // Arbitrary value
) (
   input  wire logic                          clk_sys_i,
   input  wire logic                          reset_i,
   input  wire superio_cfg_pkg::io_cycle_type io_cycle_i,
   input  wire logic                          port_strap_i,
   input  wire logic [7:0]                    ld_read_data_i,
   input  wire logic [7:0]                    unit_activate_i,
   output logic [7:0]                         rd_data_o,
   output logic                               rd_valid_o,
   output logic                               config_mode_o,
   output superio_cfg_pkg::ld_access_type     ld_access_o,
   output logic                               soft_reset_o,
   output logic [7:0]                         direct_pd_o,
   output logic [7:0]                         auto_pd_o,
   output logic [7:0]                         unit_deny_o,
   output logic [7:0]                         unit_reset_o,
   output logic                               keyboard_strap_ctrl_o,
   output logic [7:0]                         serial_second_ldn_o,
   output logic [7:0]                         serial_third_ldn_o
);
   import superio_cfg_pkg::*;

   typedef struct packed {
      io_cycle_type  cyc_s1;
      io_cycle_type  cyc_s2;
      logic          wr_s3;
      logic          rd_s3;
      logic          strap_s1;
      logic          strap_s2;
      logic [1:0]    strap_fill;
      logic          strap_taken;
      logic          strap_high;
      key_state_type key;
      logic          config_mode;
      logic [7:0]    index;
      logic [7:0]    ldn;
      logic [7:0]    direct_pd;
      logic [7:0]    auto_pd;
      logic [7:0]    swap;
      logic          soft_reset;
      logic          kbd_strap;
      logic [7:0]    deny;
      logic [7:0]    unit_reset;
      logic [7:0]    ser2_ldn;
      logic [7:0]    ser3_ldn;
      ld_access_type ld;
      logic [7:0]    rd_data;
      logic          rd_valid;
   } state_type;

   state_type state;
   state_type next_state;

   logic       wr_edge;
   logic       rd_edge;
   logic [15:0] cfg_port;
   logic       hit_cfg;
   logic       hit_data;
   logic [7:0] wdata;
   logic [7:0] active;

   ////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb begin
      next_state = state;

      // Pin synchronisers
      next_state.cyc_s1   = io_cycle_i;
      next_state.cyc_s2   = state.cyc_s1;
      next_state.wr_s3    = state.cyc_s2.wr;
      next_state.rd_s3    = state.cyc_s2.rd;
      next_state.strap_s1 = port_strap_i;
      next_state.strap_s2 = state.strap_s1;

      wr_edge = state.cyc_s2.wr && !state.wr_s3;
      rd_edge = state.cyc_s2.rd && !state.rd_s3;
      wdata   = state.cyc_s2.data;

      // Strap caught once the synchroniser holds a pin value
      if (!state.strap_taken) begin
         if (state.strap_fill == STRAP_SETTLE) begin
            next_state.strap_taken = 1'b1;
            next_state.strap_high  = state.strap_s2;
         end else begin
            next_state.strap_fill = 2'(state.strap_fill + 2'h1);
         end
      end
      cfg_port = state.strap_high ? PORT_BASE_HIGH : PORT_BASE_LOW;
      hit_cfg  = state.strap_taken && (state.cyc_s2.addr == cfg_port);
      hit_data = state.strap_taken
                 && (state.cyc_s2.addr == 16'(cfg_port + DATA_PORT_OFS));

      next_state.soft_reset = 1'b0;
      next_state.rd_valid   = 1'b0;
      next_state.ld.wr      = 1'b0;
      next_state.ld.rd      = 1'b0;

      // Key detector and index writes on the config port
      if (wr_edge && hit_cfg) begin
         unique case (state.key)
            KEY_IDLE: begin
               if (wdata == KEY_FIRST) begin
                  next_state.key = KEY_ARMED;
               end
            end
            KEY_ARMED: begin
               if (wdata == KEY_SECOND) begin
                  next_state.key = KEY_OPEN;
               end else if (wdata != KEY_FIRST) begin
                  next_state.key = KEY_IDLE;
               end
            end
            KEY_OPEN: begin
               if (wdata == KEY_EXIT) begin
                  next_state.key = KEY_IDLE;
               end else begin
                  next_state.index = wdata;
               end
            end
         endcase
      end

      // Data port writes, configuration mode only
      if (wr_edge && hit_data && state.key == KEY_OPEN) begin
         unique case (state.index)
            IDX_SOFT_RESET: begin
               next_state.soft_reset = wdata[SOFT_RESET_BIT];
            end
            IDX_LDN_SELECT: begin
               next_state.ldn = wdata;
            end
            IDX_DIRECT_PD: begin
               next_state.direct_pd = wdata & DIRECT_PD_MASK;
            end
            IDX_AUTO_PD: begin
               next_state.auto_pd = wdata & AUTO_PD_MASK;
            end
            IDX_SERIAL_SWAP: begin
               next_state.swap = wdata & SWAP_MASK;
            end
            default: begin
               // Identification is read-only
               if (state.index >= IDX_LD_FIRST) begin
                  next_state.ld.wr = 1'b1;
                  next_state.ld.data = wdata;
               end
            end
         endcase
      end

      // Data port reads, configuration mode only
      if (rd_edge && hit_data && state.key == KEY_OPEN) begin
         next_state.rd_valid = 1'b1;
         unique case (state.index)
            IDX_LDN_SELECT:  next_state.rd_data = state.ldn;
            IDX_VERSION:     next_state.rd_data = VERSION_VALUE;
            IDX_IDENT_LOW:   next_state.rd_data = IDENT_LOW;
            IDX_IDENT_HIGH:  next_state.rd_data = IDENT_HIGH;
            IDX_DIRECT_PD:   next_state.rd_data = state.direct_pd;
            IDX_AUTO_PD:     next_state.rd_data = state.auto_pd;
            IDX_SERIAL_SWAP: next_state.rd_data = state.swap;
            default: begin
               if (state.index >= IDX_LD_FIRST) begin
                  next_state.ld.rd   = 1'b1;
                  next_state.rd_data = ld_read_data_i;
               end else begin
                  next_state.rd_data = 8'h00;
               end
            end
         endcase
      end

      // Soft reset loads chip-level defaults; mode is kept
      if (state.soft_reset) begin
         next_state.ldn       = LDN_RESET;
         next_state.direct_pd = DIRECT_PD_RESET;
         next_state.auto_pd   = AUTO_PD_RESET;
         next_state.swap      = SWAP_RESET;
      end

      // Keyboard unit handed to register control once configured
      if (state.key == KEY_OPEN) begin
         next_state.kbd_strap = 1'b0;
      end

      // Unit control outputs
      active = unit_activate_i;
      if (state.kbd_strap) begin
         active[UNIT_KEYBOARD] = 1'b1;
      end
      next_state.unit_reset = ~active;
      next_state.deny = next_state.direct_pd | ~active;
      next_state.ser2_ldn = next_state.swap[SWAP_BIT] ? SERIAL_LDN_B
                                                     : SERIAL_LDN_A;
      next_state.ser3_ldn = next_state.swap[SWAP_BIT] ? SERIAL_LDN_A
                                                     : SERIAL_LDN_B;
      next_state.ld.ldn   = next_state.ldn;
      next_state.ld.index = next_state.index;
      next_state.config_mode = (next_state.key == KEY_OPEN);
   end

   ////////////////////////////////////////////////////////////////////////
   // State register

   always_ff @(posedge clk_sys_i or posedge reset_i) begin
      if (reset_i) begin
         state             <= '0;
         state.key         <= KEY_IDLE;
         state.ldn         <= LDN_RESET;
         state.direct_pd   <= DIRECT_PD_RESET;
         state.auto_pd     <= AUTO_PD_RESET;
         state.swap        <= SWAP_RESET;
         state.kbd_strap   <= 1'b1;
         state.deny        <= ~ACTIVE_RESET;
         state.unit_reset  <= ~ACTIVE_RESET;
         state.ser2_ldn    <= SERIAL_LDN_B;
         state.ser3_ldn    <= SERIAL_LDN_A;
      end else begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs

   assign rd_data_o             = state.rd_data;
   assign rd_valid_o            = state.rd_valid;
   assign config_mode_o         = state.config_mode;
   assign ld_access_o           = state.ld;
   assign soft_reset_o          = state.soft_reset;
   assign direct_pd_o           = state.direct_pd;
   assign auto_pd_o             = state.auto_pd;
   assign unit_deny_o           = state.deny;
   assign unit_reset_o          = state.unit_reset;
   assign keyboard_strap_ctrl_o = state.kbd_strap;
   assign serial_second_ldn_o   = state.ser2_ldn;
   assign serial_third_ldn_o    = state.ser3_ldn;

endmodule

/* verification/superio_cfg_sva.sv */
// Checker for the configuration port block, on its ports only.
// Assumes a bind to each instance of the block.
`timescale 1ns/1ps

module superio_cfg_chk (
   input wire logic                      clk_sys_i,
   input wire logic                      reset_i,
   input wire superio_cfg_pkg::io_cycle_type io_cycle_i,
   input wire logic [7:0]                unit_activate_i,
   input wire logic                      rd_valid_o,
   input wire logic                      config_mode_o,
   input wire superio_cfg_pkg::ld_access_type ld_access_o,
   input wire logic                      soft_reset_o,
   input wire logic [7:0]                direct_pd_o,
   input wire logic [7:0]                auto_pd_o,
   input wire logic [7:0]                unit_deny_o,
   input wire logic [7:0]                unit_reset_o,
   input wire logic                      keyboard_strap_ctrl_o,
   input wire logic [7:0]                serial_second_ldn_o,
   input wire logic [7:0]                serial_third_ldn_o
);
   import superio_cfg_pkg::*;
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);
////////////////////////////////////////////////////////////////////////////
   property p_enter; $rose(config_mode_o) |->
      $past(io_cycle_i.data) == KEY_SECOND; endproperty
   a_enter: assert property (p_enter) else $error("entry no key");
   property p_exit; $fell(config_mode_o) |->
      $past(io_cycle_i.data) == KEY_EXIT; endproperty
   a_exit: assert property (p_exit) else $error("exit no key");
   property p_kbd; $past(config_mode_o) |-> !keyboard_strap_ctrl_o;
   endproperty
   a_kbd: assert property (p_kbd) else $error("strap control kept");
   property p_cfg; (rd_valid_o || ld_access_o.wr || ld_access_o.rd) |->
      config_mode_o; endproperty
   a_cfg: assert property (p_cfg) else $error("access in normal");
   property p_rd; rd_valid_o |=> !rd_valid_o; endproperty
   a_rd: assert property (p_rd) else $error("long read valid");
   property p_soft; soft_reset_o |=> !soft_reset_o && direct_pd_o == 8'h00
      && auto_pd_o == 8'h00 && ld_access_o.ldn == LDN_RESET; endproperty
   a_soft: assert property (p_soft) else $error("soft reset");
   property p_bits; (direct_pd_o & ~DIRECT_PD_MASK) == 8'h00 &&
      (auto_pd_o & ~AUTO_PD_MASK) == 8'h00; endproperty
   a_bits: assert property (p_bits) else $error("fixed bits");
   property p_deny; $stable(direct_pd_o) && $stable(unit_activate_i) &&
      $stable(keyboard_strap_ctrl_o) |-> unit_deny_o == (direct_pd_o |
      ~(unit_activate_i | {keyboard_strap_ctrl_o, 7'h00})) &&
      unit_reset_o == ~(unit_activate_i | {keyboard_strap_ctrl_o, 7'h00});
   endproperty
   a_deny: assert property (p_deny) else $error("deny");
   property p_swap; serial_second_ldn_o == SERIAL_LDN_A ?
      serial_third_ldn_o == SERIAL_LDN_B : serial_second_ldn_o ==
      SERIAL_LDN_B && serial_third_ldn_o == SERIAL_LDN_A; endproperty
   a_swap: assert property (p_swap) else $error("device numbers");
   c_enter: cover property ($rose(config_mode_o));
   c_exit: cover property ($fell(config_mode_o));
   c_soft: cover property (soft_reset_o);
endmodule

bind superio_config_port superio_cfg_chk chk (.clk_sys_i, .reset_i,
   .io_cycle_i, .unit_activate_i, .rd_valid_o, .config_mode_o,
   .ld_access_o, .soft_reset_o, .direct_pd_o, .auto_pd_o, .unit_deny_o,
   .unit_reset_o, .keyboard_strap_ctrl_o, .serial_second_ldn_o,
   .serial_third_ldn_o);

/* verification/isa_host_model.sv */
// Host model issuing ISA I/O port cycles to the configuration block.
// Assumes callers enter io_access just after a rising clock edge.
`timescale 1ns/1ps

module isa_host_model (
   input  wire logic                     clk_i,
   output superio_cfg_pkg::io_cycle_type cycle_o
);
   import superio_cfg_pkg::*;
   initial cycle_o = '0;
////////////////////////////////////////////////////////////////////////////
   // Address and data settle a cycle before the strobe, bus inverted after
   task automatic io_access(input logic wr, input logic [15:0] addr,
                            input logic [7:0] data);
      cycle_o.addr <= addr;
      cycle_o.data <= data;
      @(posedge clk_i);
      cycle_o.wr <= wr;
      cycle_o.rd <= !wr;
      repeat (4) @(posedge clk_i);
      cycle_o <= {~addr, ~data, 2'b00};
      repeat (3) @(posedge clk_i);
   endtask
endmodule

/* verification/tb.sv */
// Self-checking bench for the configuration port block.
// Assumes the host model and the bound checker are compiled with it.
`timescale 1ns/1ps

module tb;
   import superio_cfg_pkg::*;
   localparam logic [7:0] VER   = 8'h3c; // Arbitrary value
   localparam logic [7:0] ID_LO = 8'h96; // Arbitrary value
   localparam logic [7:0] ID_HI = 8'h69; // Arbitrary value
   logic          clk_sys_i = 1'b0;
   logic          reset_i = 1'b1;
   logic          port_strap_i = 1'b1;
   logic [7:0]    ld_read_data_i = 8'h00;
   logic [7:0]    unit_activate_i = ACTIVE_RESET;
   io_cycle_type  io_cycle;
   ld_access_type ld_access_o;
   logic rd_valid_o, config_mode_o, soft_reset_o, keyboard_strap_ctrl_o;
   logic [7:0] rd_data_o, direct_pd_o, auto_pd_o, unit_deny_o, unit_reset_o;
   logic [7:0] serial_second_ldn_o, serial_third_ldn_o, r, d, act;
   logic [15:0] cfg_port = PORT_BASE_HIGH;
   logic [7:0] exp_q[$];
   logic [7:0] tab [8][4] = '{
      '{IDX_LDN_SELECT, LDN_RESET, 8'h04, 8'h04},
      '{IDX_DIRECT_PD, DIRECT_PD_RESET, 8'hff, DIRECT_PD_MASK},
      '{IDX_AUTO_PD, AUTO_PD_RESET, 8'hff, AUTO_PD_MASK},
      '{IDX_SERIAL_SWAP, SWAP_RESET, 8'hdf, 8'h00},
      '{IDX_IDENT_LOW, ID_LO, 8'hff, ID_LO},
      '{IDX_IDENT_HIGH, ID_HI, 8'h00, ID_HI},
      '{IDX_VERSION, VER, 8'hff, VER},
      '{8'h2c, 8'h00, 8'hff, 8'h00}};
   int errors = 0;
   int num_checks = 0;
   int soft_seen = 0;
   int ldwr_seen = 0;
   int ldrd_seen = 0;

   isa_host_model host (.clk_i(clk_sys_i), .cycle_o(io_cycle));
   superio_config_port #(.VERSION_VALUE(VER), .IDENT_LOW(ID_LO),
      .IDENT_HIGH(ID_HI)) dut (.clk_sys_i, .reset_i, .io_cycle_i(io_cycle),
      .port_strap_i, .ld_read_data_i, .unit_activate_i, .rd_data_o,
      .rd_valid_o, .config_mode_o, .ld_access_o, .soft_reset_o,
      .direct_pd_o, .auto_pd_o, .unit_deny_o, .unit_reset_o,
      .keyboard_strap_ctrl_o, .serial_second_ldn_o, .serial_third_ldn_o);
////////////////////////////////////////////////////////////////////////////
   always #10 clk_sys_i = ~clk_sys_i;

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] v);
      host.io_access(1'b1, a, v);
   endtask
   task automatic reg_wr(input logic [7:0] idx, input logic [7:0] v);
      wr(cfg_port, idx);
      wr(cfg_port + 16'h0001, v);
   endtask
   task automatic reg_rd(input logic [7:0] idx, input logic [7:0] exp);
      wr(cfg_port, idx);
      exp_q.push_back(exp);
      host.io_access(1'b0, cfg_port + 16'h0001, 8'h00);
   endtask
   task automatic key(input logic [15:0] a);
      wr(a, KEY_FIRST);
      wr(a, KEY_SECOND);
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   // Every read answer takes the oldest noted expectation
   always @(posedge clk_sys_i)
      if (rd_valid_o === 1'b1)
         chk(rd_data_o, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);

   always @(posedge clk_sys_i) begin
      soft_seen += int'(soft_reset_o === 1'b1);
      ldwr_seen += int'(ld_access_o.wr === 1'b1);
      ldrd_seen += int'(ld_access_o.rd === 1'b1);
   end

   initial begin
      repeat (20000) @(posedge clk_sys_i);
      errors++;
      end_sim;
   end

   initial begin
      r = 8'($urandom(32'h3823));
      repeat (3) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      @(posedge clk_sys_i);
      chk(8'(config_mode_o), 8'h00);
      chk(8'(keyboard_strap_ctrl_o), 8'h01);
      chk(unit_deny_o, 8'h7f);
      chk(serial_second_ldn_o, SERIAL_LDN_B);
      reg_wr(IDX_DIRECT_PD, 8'hff);
      host.io_access(1'b0, cfg_port + 16'h0001, 8'h00);
      chk(direct_pd_o, 8'h00);
      key(PORT_BASE_LOW);
      chk(8'(config_mode_o), 8'h00);
      wr(cfg_port, KEY_FIRST);
      wr(cfg_port, 8'($urandom) | 8'h80);
      wr(cfg_port, KEY_SECOND);
      chk(8'(config_mode_o), 8'h00);
      wr(cfg_port, KEY_FIRST);
      key(cfg_port);
      chk(8'(config_mode_o), 8'h01);
      chk(8'(keyboard_strap_ctrl_o), 8'h00);
      for (int i = 0; i < 8; i++) begin
         reg_rd(tab[i][0], tab[i][1]);
         reg_wr(tab[i][0], tab[i][2]);
         reg_rd(tab[i][0], tab[i][3]);
      end
      chk(serial_second_ldn_o, SERIAL_LDN_A);
      chk(serial_third_ldn_o, SERIAL_LDN_B);
      chk(auto_pd_o, AUTO_PD_MASK);
      act = 8'($urandom);
      unit_activate_i <= act;
      repeat (3) @(posedge clk_sys_i);
      chk(unit_deny_o, DIRECT_PD_MASK | ~act);
      chk(unit_reset_o, ~act);
      reg_wr(IDX_DIRECT_PD, 8'h00);
      chk(unit_deny_o, ~act);
      r = 8'($urandom);
      d = 8'($urandom);
      reg_wr(IDX_LDN_SELECT, r);
      reg_wr(IDX_LD_FIRST, ~r);
      chk(ld_access_o.ldn, r);
      chk(ld_access_o.data, ~r);
      chk(ld_access_o.index, IDX_LD_FIRST);
      ld_read_data_i <= d;
      reg_rd(IDX_LD_FIRST, d);
      chk(8'(ldwr_seen), 8'h01);
      chk(8'(ldrd_seen), 8'h01);
      wr(cfg_port, KEY_EXIT);
      chk(8'(config_mode_o), 8'h00);
      key(cfg_port);
      reg_rd(IDX_LDN_SELECT, r);
      reg_wr(IDX_DIRECT_PD, 8'hff);
      reg_wr(IDX_SOFT_RESET, 8'h01);
      chk(8'(config_mode_o), 8'h01);
      chk(8'(soft_seen), 8'h01);
      for (int i = 0; i < 4; i++)
         reg_rd(tab[i][0], tab[i][1]);
      unit_activate_i <= 8'h00;
      port_strap_i <= 1'b0;
      reset_i <= 1'b1;
      repeat (3) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      @(posedge clk_sys_i);
      cfg_port = PORT_BASE_LOW;
      key(PORT_BASE_HIGH);
      chk(8'(config_mode_o), 8'h00);
      chk(unit_deny_o, 8'h7f);
      key(cfg_port);
      chk(unit_deny_o, 8'hff);
      reg_rd(IDX_LDN_SELECT, LDN_RESET);
      chk(8'(exp_q.size()), 8'h00);
      end_sim;
   end
endmodule
